// *** design/mcs_defines.svh ***
// Purpose: offsets, field positions and reset values of the carrier select block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: register offsets are local choices
`ifndef MCS_DEFINES_SVH
`define MCS_DEFINES_SVH

`define MCS_OFS_HICAR        12'h000
`define MCS_OFS_LOCAR        12'h004
`define MCS_OFS_MODCTL       12'h008
`define MCS_OFS_MODSRC       12'h00C

`define MCS_BIT_PIN_OFF      7
`define MCS_BIT_INVERT       6
`define MCS_BIT_SYNC         5
`define MCS_CAR_WMASK        8'hEF

`define MCS_BIT_MOD_ON       7
`define MCS_BIT_PIN_OE       6
`define MCS_BIT_SLEW         5
`define MCS_BIT_OUT_INV      4
`define MCS_BIT_OUT_VIEW     3
`define MCS_BIT_SOFT_LEVEL   0
`define MCS_MODCTL_WMASK     8'hF1
`define MCS_MODCTL_RESET     8'h20

`define MCS_MODSRC_WMASK     8'h8F
`define MCS_CAR_RESET        8'h00
`define MCS_MODSRC_RESET     8'h00

`define MCS_SRC_GROUND       4'h0
`define MCS_SRC_PIN_A        4'h1
`define MCS_SRC_PIN_B        4'h2
`define MCS_SRC_REFCLK       4'h3
`define MCS_SRC_PWM0         4'h4
`define MCS_NUM_PWM          4
`define MCS_NUM_MODSRC       11

`endif

// *** design/mcs_pkg.sv ***
// Purpose: types shared by the carrier select block
// Assumes: widths fixed as documented
// Notes: constants live in mcs_defines.svh
package mcs_pkg;
   typedef logic [3:0] mcs_sel_t;

   typedef struct packed {
      logic     pinOff;
      logic     invert;
      logic     edgeSync;
      logic     unused;
      mcs_sel_t select;
   } mcs_carrier_s;

   typedef struct packed {
      logic       carrierPinA;
      logic       carrierPinB;
      logic       refClock;
      logic [3:0] pwm;
   } mcs_sources_s;

   typedef enum logic [1:0] {
      MCS_USE_LO  = 2'b00,
      MCS_WAIT_HI = 2'b01,
      MCS_USE_HI  = 2'b11,
      MCS_WAIT_LO = 2'b10
   } mcs_state_e;
endpackage

// *** design/mcs_carrier_path.sv ***
// Purpose: picks and conditions one carrier
// Assumes: sources already synchronised to clk_sys
// Notes: reserved codes give a constant low source
`timescale 1ns/10ps
`include "mcs_defines.svh"
module mcs_carrier_path (
   // configuration
   input  wire mcs_pkg::mcs_carrier_s cfg,
   // sources
   input  wire mcs_pkg::mcs_sources_s src,
   // results
   output logic                       carrier,
   output logic [6:0]                 pinDriveOff
);
   import mcs_pkg::*;

   function automatic logic pickSource(input mcs_sel_t sel, input mcs_sources_s s);
      logic r;
      r = 1'b0;
      unique case (sel)
         `MCS_SRC_GROUND: r = 1'b0;
         `MCS_SRC_PIN_A:  r = s.carrierPinA;
         `MCS_SRC_PIN_B:  r = s.carrierPinB;
         `MCS_SRC_REFCLK: r = s.refClock;
         4'h4, 4'h5, 4'h6, 4'h7: r = s.pwm[sel[1:0]];
         default:         r = 1'b0;
      endcase
      return r;
   endfunction

   wire picked;
   assign picked = pickSource(cfg.select, src);
   assign carrier = picked ^ cfg.invert;

   // bit i of pinDriveOff stands for source code i+1
   always_comb begin
      pinDriveOff = 7'h00;
      if (cfg.pinOff && cfg.select != `MCS_SRC_GROUND && !cfg.select[3]) begin
         pinDriveOff[cfg.select[2:0] - 3'h1] = 1'b1;
      end
   end
endmodule // mcs_carrier_path

// *** design/mcs_sync2.sv ***
// Purpose: two-flop synchroniser for a bundle of pin levels
// Assumes: levels, not pulses
// Notes: first stage feeds only the second
`timescale 1ns/10ps
module mcs_sync2 #(
   parameter int W = 8
) (
   // clock
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         clkEn,
   // data
   input  wire logic [W-1:0] din,
   output logic [W-1:0]      dout
);
   logic [W-1:0] stage1_reg;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stage1_reg <= '0;
         dout       <= '0;
      end else if (clkEn) begin
         stage1_reg <= din;
         dout       <= stage1_reg;
      end
   end
endmodule // mcs_sync2

// *** design/mcs_modulator.sv ***
// Functional notes
// - high pin-off bit set disables the chosen high source's pin drive
// - high invert bit inverts the selected high carrier
// - high sync: switch high to low waits for high carrier falling edge
// - high select: ground, pin a, pin b, reference clock, four pwm outputs
// - select codes 1000 to 1111 connect no source
// - low pin-off bit set disables the chosen low source's pin drive
// - low invert bit inverts the selected low carrier
// - low sync: switch low to high waits for low carrier falling edge
// - low select uses the same encoding as high select
// - bit 4 of both carrier registers reads zero, writes ignored
// - carrier fields have no defined power-on value, survive other resets
// - modulation level one picks high carrier, zero picks low
// - modulator off gives no output; on mixes carriers and modulation
// - output invert bit inverts the mixed carrier before the enable; a disabled modulator still drives low
//
// Purpose: carrier selection, conditioning and mixing, with APB registers
// Assumes: clk_sys 50 MHz; all pin sources asynchronous
// Notes: rst models the non-power-on resets; carrier fields keep value through it
`timescale 1ns/10ps
`include "mcs_defines.svh"
module mcs_modulator (
   // clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   input  wire logic                 clkEn,
   // apb slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   // carrier and modulation sources
   input  wire mcs_pkg::mcs_sources_s carrierSrc,
   input  wire logic [10:1]          modSrc,
   // outputs
   output logic                      modOut,
   output logic                      modPinOe,
   output logic [6:0]                hiPinDriveOff,
   output logic [6:0]                loPinDriveOff,
   output logic                      modSrcPinDriveOff
);
   import mcs_pkg::*;

   mcs_carrier_s hiCfg_reg;
   mcs_carrier_s loCfg_reg;
   logic [7:0]   modCtl_reg;
   logic [7:0]   modSrc_reg;
   mcs_state_e   state_reg;
   mcs_state_e   state_next;
   logic         out_reg;
   logic         hiPrev_reg;
   logic         loPrev_reg;
   logic         outView_reg;

   mcs_sources_s srcSync;
   logic [10:1]  modSync;
   logic         hiCarrier;
   logic         loCarrier;

   mcs_sync2 #(.W(17)) u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .clkEn   (clkEn),
      .din     ({carrierSrc, modSrc}),
      .dout    ({srcSync, modSync})
   );

   mcs_carrier_path u_hi (
      .cfg         (hiCfg_reg),
      .src         (srcSync),
      .carrier     (hiCarrier),
      .pinDriveOff (hiPinDriveOff)
   );

   mcs_carrier_path u_lo (
      .cfg         (loCfg_reg),
      .src         (srcSync),
      .carrier     (loCarrier),
      .pinDriveOff (loPinDriveOff)
   );

   // bus decode; the slave answers in the access cycle with no wait
   wire wrEn    = psel && penable && pwrite && clkEn;
   wire hitHi   = paddr == `MCS_OFS_HICAR;
   wire hitLo   = paddr == `MCS_OFS_LOCAR;
   wire hitCtl  = paddr == `MCS_OFS_MODCTL;
   wire hitSrc  = paddr == `MCS_OFS_MODSRC;
   wire mapped  = hitHi || hitLo || hitCtl || hitSrc;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // bit 4 masked on read and write
   wire [7:0] wrCar = pwdata[7:0] & `MCS_CAR_WMASK;

   // carrier registers have no reset term so they hold across rst
   always_ff @(posedge clk_sys) begin
      if (wrEn && hitHi) begin
         hiCfg_reg <= wrCar;
      end
      if (wrEn && hitLo) begin
         loCfg_reg <= wrCar;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         modCtl_reg <= `MCS_MODCTL_RESET;
         modSrc_reg <= `MCS_MODSRC_RESET;
      end else if (wrEn && hitCtl) begin
         modCtl_reg <= pwdata[7:0] & `MCS_MODCTL_WMASK;
      end else if (wrEn && hitSrc) begin
         modSrc_reg <= pwdata[7:0] & `MCS_MODSRC_WMASK;
      end
   end

   wire [7:0] ctlView = {modCtl_reg[7:4], outView_reg, modCtl_reg[2:0]};
   wire [7:0] rdByte  = hitHi  ? (hiCfg_reg & `MCS_CAR_WMASK) :
                        hitLo  ? (loCfg_reg & `MCS_CAR_WMASK) :
                        hitCtl ? ctlView :
                        hitSrc ? modSrc_reg : 8'h00;
   assign prdata = {24'h000000, rdByte};

   // modulation level: soft bit or a synchronised source; reserved gives low
   wire [3:0] mSel = modSrc_reg[3:0];
   wire inRange    = mSel != 4'h0 && mSel <= 4'hA;
   wire level = (mSel == 4'h0) ? modCtl_reg[`MCS_BIT_SOFT_LEVEL] :
                inRange ? modSync[mSel] : 1'b0;
   assign modSrcPinDriveOff = modSrc_reg[7];

   wire hiFall  = hiPrev_reg && !hiCarrier;
   wire loFall  = loPrev_reg && !loCarrier;
   wire hiSync  = hiCfg_reg.edgeSync;
   wire loSync  = loCfg_reg.edgeSync;

   // carrier switch with optional edge wait
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         MCS_USE_LO:  if (level) state_next = (loSync && !loFall) ? MCS_WAIT_HI : MCS_USE_HI;
         MCS_WAIT_HI: if (!level) state_next = MCS_USE_LO;
                      else if (loFall) state_next = MCS_USE_HI;
         MCS_USE_HI:  if (!level) state_next = (hiSync && !hiFall) ? MCS_WAIT_LO : MCS_USE_LO;
         MCS_WAIT_LO: if (level) state_next = MCS_USE_HI;
                      else if (hiFall) state_next = MCS_USE_LO;
      endcase
   end

   wire useHi = state_reg == MCS_USE_HI || state_reg == MCS_WAIT_LO;
   wire mixed = useHi ? hiCarrier : loCarrier;
   wire modOn = modCtl_reg[`MCS_BIT_MOD_ON];

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_reg   <= MCS_USE_LO;
         out_reg     <= 1'b0;
         hiPrev_reg  <= 1'b0;
         loPrev_reg  <= 1'b0;
         outView_reg <= 1'b0;
      end else if (clkEn) begin
         state_reg   <= state_next;
         hiPrev_reg  <= hiCarrier;
         loPrev_reg  <= loCarrier;
         // polarity first, enable last: a disabled modulator stays low
         out_reg     <= modOn & (mixed ^ modCtl_reg[`MCS_BIT_OUT_INV]);
         outView_reg <= out_reg;
      end
   end

   assign modOut   = out_reg;
   assign modPinOe = modCtl_reg[`MCS_BIT_PIN_OE];

   // helper: a carrier register is known once software has written it; before
   // that its power-on value is undefined, so the checks on it stay quiet
   // limitation: rst clears these too, so holding across rst is left to the bench
   logic hiKnown_reg;
   logic loKnown_reg;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hiKnown_reg <= 1'b0;
         loKnown_reg <= 1'b0;
      end else begin
         if (wrEn && hitHi) begin
            hiKnown_reg <= 1'b1;
         end
         if (wrEn && hitLo) begin
            loKnown_reg <= 1'b1;
         end
      end
   end

   property p_hi_hold;
      @(posedge clk_sys) disable iff (rst)
      (clkEn && state_reg == MCS_USE_HI && !level && hiSync && !hiFall)
         |=> state_reg == MCS_WAIT_LO;
   endproperty
   a_hi_hold: assert property (p_hi_hold) else $error("high sync did not wait");

   property p_lo_hold;
      @(posedge clk_sys) disable iff (rst)
      (clkEn && state_reg == MCS_WAIT_HI && level && !loFall) |=> state_reg == MCS_WAIT_HI;
   endproperty
   a_lo_hold: assert property (p_lo_hold) else $error("low sync switched early");

   property p_nosync;
      @(posedge clk_sys) disable iff (rst)
      (clkEn && state_reg == MCS_USE_LO && level && !loSync) |=> useHi;
   endproperty
   a_nosync: assert property (p_nosync) else $error("unsynced switch late");

   property p_off;
      @(posedge clk_sys) disable iff (rst)
      (clkEn && !modOn) |=> !modOut;
   endproperty
   a_off: assert property (p_off) else $error("output while disabled");

   property p_pol;
      @(posedge clk_sys) disable iff (rst)
      clkEn |=> modOut == ($past(modOn)
                & ($past(mixed) ^ $past(modCtl_reg[`MCS_BIT_OUT_INV])));
   endproperty
   a_pol: assert property (p_pol) else $error("output polarity wrong");

   property p_bit4;
      @(posedge clk_sys) disable iff (rst)
      (psel && (hitHi || hitLo)) |-> prdata[4] == 1'b0;
   endproperty
   a_bit4: assert property (p_bit4) else $error("bit 4 reads one");

   property p_level;
      @(posedge clk_sys) disable iff (rst)
      (clkEn && mSel == 4'h0) |-> level == modCtl_reg[`MCS_BIT_SOFT_LEVEL];
   endproperty
   a_level: assert property (p_level) else $error("soft level not used");

   property p_hold;
      @(posedge clk_sys) (hiKnown_reg && !(wrEn && hitHi)) |=> hiCfg_reg == $past(hiCfg_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("high carrier register changed");

   property p_pinoff;
      @(posedge clk_sys) disable iff (rst)
      (!hiCfg_reg.pinOff || hiCfg_reg.select[3]) |-> hiPinDriveOff == 7'h00;
   endproperty
   a_pinoff: assert property (p_pinoff) else $error("pin drive off spurious");

   property p_lo_keep;
      @(posedge clk_sys) (loKnown_reg && !(wrEn && hitLo)) |=> loCfg_reg == $past(loCfg_reg);
   endproperty
   a_lo_keep: assert property (p_lo_keep) else $error("low carrier register changed");

   property p_lo_pinoff;
      @(posedge clk_sys) disable iff (rst)
      (!loCfg_reg.pinOff || loCfg_reg.select[3]) |-> loPinDriveOff == 7'h00;
   endproperty
   a_lo_pinoff: assert property (p_lo_pinoff) else $error("low pin drive off spurious");

   property p_hi_pinon;
      @(posedge clk_sys) disable iff (rst)
      (hiKnown_reg && hiCfg_reg.pinOff && !hiCfg_reg.select[3] && hiCfg_reg.select != 4'h0)
         |-> hiPinDriveOff == (7'h01 << (hiCfg_reg.select[2:0] - 3'h1));
   endproperty
   a_hi_pinon: assert property (p_hi_pinon) else $error("high pin drive not off");

   property p_hi_reserved;
      @(posedge clk_sys) disable iff (rst)
      (hiKnown_reg && hiCfg_reg.select[3]) |-> hiCarrier == hiCfg_reg.invert;
   endproperty
   a_hi_reserved: assert property (p_hi_reserved) else $error("high code not idle");

   property p_lo_reserved;
      @(posedge clk_sys) disable iff (rst)
      (loKnown_reg && loCfg_reg.select[3]) |-> loCarrier == loCfg_reg.invert;
   endproperty
   a_lo_reserved: assert property (p_lo_reserved) else $error("low code not idle");

   property p_hi_ground;
      @(posedge clk_sys) disable iff (rst)
      (hiKnown_reg && hiCfg_reg.select == `MCS_SRC_GROUND) |-> hiCarrier == hiCfg_reg.invert;
   endproperty
   a_hi_ground: assert property (p_hi_ground) else $error("ground not low");

   // a pending switch completes on the awaited falling edge
   sequence s_hi_edge_seen;
      clkEn && state_reg == MCS_WAIT_LO && !level && hiFall;
   endsequence

   sequence s_lo_edge_seen;
      clkEn && state_reg == MCS_WAIT_HI && level && loFall;
   endsequence

   property p_hi_release;
      @(posedge clk_sys) disable iff (rst)
      s_hi_edge_seen |=> state_reg == MCS_USE_LO;
   endproperty
   a_hi_release: assert property (p_hi_release) else $error("high edge no release");

   property p_lo_release;
      @(posedge clk_sys) disable iff (rst)
      s_lo_edge_seen |=> state_reg == MCS_USE_HI;
   endproperty
   a_lo_release: assert property (p_lo_release) else $error("low edge no release");

   property p_back_nosync;
      @(posedge clk_sys) disable iff (rst)
      (clkEn && state_reg == MCS_USE_HI && !level && !hiSync) |=> !useHi;
   endproperty
   a_back_nosync: assert property (p_back_nosync) else $error("unsynced return late");
endmodule // mcs_modulator

// *** testbench/mcs_source_model.sv ***
// Purpose: far-side sources of carrier and modulation levels
// Assumes: the bench sets wanted levels; slow mode adds one edge of lag
// Notes: plain levels; these sources have no pin drive of their own
`timescale 1ns/10ps
module mcs_source_model (
   // clock
   input  wire logic             clk_sys,
   // control
   input  wire logic             slow,
   input  wire logic [16:0]      want,
   // sources
   output mcs_pkg::mcs_sources_s carrierSrc,
   output logic [10:1]           modSrc
);
   import mcs_pkg::*;
   logic [16:0] lag_reg;
   // slow mode shows old levels one more edge, as a lazy far side would
   always_ff @(posedge clk_sys) begin
      lag_reg <= want;
      {modSrc, carrierSrc} <= slow ? lag_reg : want;
   end
endmodule // mcs_source_model

// *** testbench/modulator_carrier_select_test.sv ***
// Purpose: self-checking bench of the carrier select block
// Assumes: APB answers at once; sources steady before each compare
// Notes: a disabled modulator is expected to drive low
`timescale 1ns/10ps
`include "mcs_defines.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
   $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module modulator_carrier_select_test;
   import mcs_pkg::*;
   localparam int SETTLE = 8;
   logic         clk_sys, rst, clkEn, psel, penable, pwrite, slow, err;
   logic         pready, pslverr, modOut, modPinOe, modSrcPinDriveOff;
   logic [11:0]  paddr;
   logic [31:0]  pwdata, prdata, rd;
   logic [6:0]   hiPinDriveOff, loPinDriveOff;
   logic [16:0]  want;
   logic [10:1]  modSrc;
   logic [7:0]   hiR, loR, ctlR, srcR, w;
   mcs_sources_s carrierSrc;
   int           err_count, num_checks;

   mcs_modulator uut (.clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .carrierSrc(carrierSrc), .modSrc(modSrc),
      .modOut(modOut), .modPinOe(modPinOe), .hiPinDriveOff(hiPinDriveOff),
      .loPinDriveOff(loPinDriveOff), .modSrcPinDriveOff(modSrcPinDriveOff));
   mcs_source_model partner (.clk_sys(clk_sys), .slow(slow), .want(want),
      .carrierSrc(carrierSrc), .modSrc(modSrc));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic complete_run();
      if (err_count == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
      int n;
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= {24'h0, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge clk_sys); n++; end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin err_count++; complete_run(); end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk_sys);
   endtask

   // reserved codes feed a constant low before the inverter
   function automatic logic carOf(logic [7:0] r, mcs_sources_s s);
      logic [7:0] v;
      v = {s.pwm, s.refClock, s.carrierPinB, s.carrierPinA, 1'b0};
      return (r[3] ? 1'b0 : v[r[2:0]]) ^ r[6];
   endfunction

   function automatic logic [6:0] offOf(logic [7:0] r);
      return (r[7] && !r[3] && r[2:0] != 3'h0) ? 7'h01 << (r[2:0] - 3'h1) : 7'h00;
   endfunction

   function automatic logic expOut();
      logic lvl;
      lvl = (srcR[3:0] == 4'h0) ? ctlR[0] : (srcR[3:0] <= 4'hA) ? want[6 + srcR[3:0]] : 1'b0;
      return ctlR[7] & (ctlR[4] ^ (lvl ? carOf(hiR, want[6:0]) : carOf(loR, want[6:0])));
   endfunction

   initial begin
      rst = 1'b1; clkEn = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h0; pwdata = 32'h0; want = 17'h0; slow = 1'b0;
      err_count = 0; num_checks = 0;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      void'($urandom(90));
      for (int i = 0; i < 48; i++) begin
         w = ($urandom() & 8'hDF) | i[3:0];
         apb(1'b1, `MCS_OFS_HICAR, w);
         hiR = w & 8'hEF;
         w = ($urandom() & 8'hD0) | (4'hF - i[3:0]);
         apb(1'b1, `MCS_OFS_LOCAR, w);
         loR = w & 8'hEF;
         ctlR = $urandom() & 8'hF1;
         apb(1'b1, `MCS_OFS_MODCTL, ctlR);
         w = $urandom();
         apb(1'b1, `MCS_OFS_MODSRC, w);
         srcR = w & 8'h8F;
         want <= $urandom();
         slow <= $urandom();
         repeat (SETTLE) @(posedge clk_sys);
         `CHK(modOut, expOut())
         `CHK(hiPinDriveOff, offOf(hiR))
         `CHK(loPinDriveOff, offOf(loR))
         apb(1'b0, `MCS_OFS_HICAR, 8'h00);
         `CHK(rd[7:0], hiR)
         apb(1'b0, `MCS_OFS_LOCAR, 8'h00);
         `CHK(rd[7:0], loR)
         apb(1'b0, `MCS_OFS_MODCTL, 8'h00);
         `CHK({modPinOe, rd[7:0]}, {ctlR[6], ctlR | {4'h0, expOut(), 3'h0}})
         apb(1'b0, `MCS_OFS_MODSRC, 8'h00);
         `CHK({modSrcPinDriveOff, rd[7:0]}, {srcR[7], srcR})
      end
      // a write while the clock enable is low must be lost
      clkEn <= 1'b0;
      apb(1'b1, `MCS_OFS_HICAR, ~hiR);
      clkEn <= 1'b1;
      apb(1'b0, 12'h010, 8'h00);
      `CHK({err, rd}, 33'h100000000)
      rst <= 1'b1;
      @(posedge clk_sys);
      rst <= 1'b0;
      apb(1'b0, `MCS_OFS_HICAR, 8'h00);
      `CHK(rd[7:0], hiR)
      apb(1'b0, `MCS_OFS_LOCAR, 8'h00);
      `CHK(rd[7:0], loR)
      apb(1'b0, `MCS_OFS_MODCTL, 8'h00);
      `CHK({modOut, rd[7:0]}, 9'h020)
      // sync: high source pin a, low source pin b
      apb(1'b1, `MCS_OFS_HICAR, 8'h21);
      apb(1'b1, `MCS_OFS_LOCAR, 8'h02);
      want <= 17'h00040;
      apb(1'b1, `MCS_OFS_MODCTL, 8'h81);
      repeat (SETTLE) @(posedge clk_sys);
      `CHK(modOut, 1'b1)
      apb(1'b1, `MCS_OFS_MODCTL, 8'h80);
      repeat (SETTLE) @(posedge clk_sys);
      `CHK(modOut, 1'b1)
      want <= 17'h00020;
      repeat (SETTLE) @(posedge clk_sys);
      `CHK(modOut, 1'b1)
      apb(1'b1, `MCS_OFS_HICAR, 8'h01);
      apb(1'b1, `MCS_OFS_LOCAR, 8'h22);
      apb(1'b1, `MCS_OFS_MODCTL, 8'h81);
      repeat (SETTLE) @(posedge clk_sys);
      `CHK(modOut, 1'b1)
      want <= 17'h00040;
      repeat (SETTLE) @(posedge clk_sys);
      `CHK(modOut, 1'b1)
      complete_run();
   end
endmodule // modulator_carrier_select_test
